//--- rtl/prmc_regs.svh
// register offsets, field positions, reset values and wake timing
// of the power reduction mode controller; included by its bare name
`ifndef PRMC_REGS_SVH
`define PRMC_REGS_SVH

// =====================================================
// byte offsets on the wishbone bus
`define PRMC_OFS_CONTROL   8'h00
`define PRMC_OFS_WAKECFG   8'h04
`define PRMC_OFS_STATUS    8'h08

// =====================================================
// control register fields
`define PRMC_BIT_HALT      0
`define PRMC_BIT_SLEEP     1
`define PRMC_BIT_LOCK      2
`define PRMC_BIT_SPARE_A   3
`define PRMC_BIT_SPARE_B   4

// =====================================================
// wake configuration fields
`define PRMC_POS_KEY_POL   0
`define PRMC_POS_KEY_EN    4
`define PRMC_POS_EXT_EN    8
`define PRMC_RST_KEY_POL   4'h0
`define PRMC_RST_KEY_EN    4'hf
`define PRMC_RST_EXT_EN    2'h3

// =====================================================
// status register fields
`define PRMC_POS_STATE     0
`define PRMC_POS_WAKESRC   4
`define PRMC_BIT_RAMBLOCK  8
`define PRMC_BIT_HOLD      9

// =====================================================
// timing: keyboard wake holds execution this many clocks
`define PRMC_KEY_WAKE_CLOCKS 1024

`endif

//--- rtl/prmc_pkg.sv
// types shared by the power reduction mode controller files
// assumes prmc_regs.svh carries the numeric constants
package prmc_pkg;

    // =====================================================
    // controller modes
    typedef enum logic [2:0] {
        PRMC_RUN,
        PRMC_IDLE,
        PRMC_PDOWN,
        PRMC_HOLD_EXT,
        PRMC_HOLD_KEY
    } prmc_state_type;

    // =====================================================
    // clock gate controls travel together
    typedef struct packed {
        logic osc;
        logic periph;
        logic cpu;
    } prmc_clk_type;

    // =====================================================
    // last wake cause, shown in status
    typedef enum logic [1:0] {
        PRMC_WAKE_NONE,
        PRMC_WAKE_IRQ,
        PRMC_WAKE_EXT,
        PRMC_WAKE_KEY
    } prmc_wake_type;

endpackage : prmc_pkg

//--- rtl/prmc_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
// assumes each bit is an independent level, no bus coherency
`timescale 1ns/100ps
`default_nettype none

module prmc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] pinLevel,
    output logic      [WIDTH-1:0] syncLevel
);

    logic [WIDTH-1:0] stage1;

    // =====================================================
    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1    <= '0;
            syncLevel <= '0;
        end else begin
            stage1    <= pinLevel;
            syncLevel <= stage1;
        end
    end

endmodule : prmc_sync

`default_nettype wire

//--- rtl/prmc_ctrl.sv
// power reduction mode controller: idle, power-down, wake and lock
// assumes a free running sys_clk that survives power-down (the
// oscillator gate is an output), a same-clock enabled interrupt
// request, and classic wishbone register access
//
// What this block does
// - idle stops cpu clock while peripherals keep their clock
// - idle keeps pc, status word, sfrs and ram untouched
// - setting halt request while unlocked enters idle after that write
// - halt and sleep together enter power-down, never idle afterwards
// - enabled interrupt in idle clears halt and restores cpu clock
// - reset pin high clears halt and restores cpu clock
// - after reset pin wake block internal ram, allow port access
// - power-down stops oscillator and all clocks, state preserved
// - setting sleep request while unlocked enters power-down
// - power-down wakes on both external irqs and four key inputs
// - wake clears sleep request, restarts oscillator and all clocks
// - external irq wake holds execution until that input releases
// - key wake resumes execution after 1024 clocks regardless of key
// - interrupt wake runs service routine then continues after entry
// - external irq wake leaves sfrs and ram unaltered
// - each key input selects high or low level wake
// - two software writable spare flags in control register
// - lock set prevents software setting halt or sleep request
// - reset pin in power-down clears sleep and restores clocks
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "prmc_regs.svh"

module prmc_ctrl #(
    parameter int KEY_WAKE_CLOCKS = `PRMC_KEY_WAKE_CLOCKS
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // wake sources
    input  wire logic                  irqPending,
    input  wire logic                  extIrqA_n,
    input  wire logic                  extIrqB_n,
    input  wire logic [3:0]            keyWakeInputs,
    input  wire logic                  resetPinLevel,
    // clock gates and cpu control
    output prmc_pkg::prmc_clk_type     clkGate,
    output logic                       execHold,
    output logic                       ramAccessBlock
);

    localparam int KEY_LAST = KEY_WAKE_CLOCKS - 1;

    // =====================================================
    // pin synchronisers
    logic [6:0] pinSync;
    prmc_sync #(.WIDTH(7)) pinSyncInst (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pinLevel  ({resetPinLevel, keyWakeInputs, extIrqB_n, extIrqA_n}),
        .syncLevel (pinSync)
    );

    wire       rstPin    = pinSync[6];
    wire [3:0] keyLevel  = pinSync[5:2];
    wire [1:0] extActive = ~pinSync[1:0];

    // =====================================================
    // state
    prmc_pkg::prmc_state_type state;
    prmc_pkg::prmc_state_type next_state;
    prmc_pkg::prmc_wake_type  wakeSrc;
    prmc_pkg::prmc_wake_type  next_wakeSrc;
    logic        haltReq;
    logic        sleepReq;
    logic        lockBit;
    logic        spareA;
    logic        spareB;
    logic [3:0]  keyPolarity;
    logic [3:0]  keyEnable;
    logic [1:0]  extEnable;
    logic [1:0]  wakeLines;
    logic [10:0] keyCount;

    // =====================================================
    // bus decode
    wire busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire busWrite  = busReq & wb_we_i;
    wire hitCtrl   = wb_adr_i == `PRMC_OFS_CONTROL;
    wire hitCfg    = wb_adr_i == `PRMC_OFS_WAKECFG;
    wire hitStat   = wb_adr_i == `PRMC_OFS_STATUS;
    wire wrCtrl    = busWrite & hitCtrl & wb_sel_i[0];
    wire wrCfgLo   = busWrite & hitCfg & wb_sel_i[0];
    wire wrCfgHi   = busWrite & hitCfg & wb_sel_i[1];

    // =====================================================
    // wake detection
    // key level compare: polarity bit high means high level wakes
    wire [3:0] keyHit  = keyEnable & ~(keyLevel ^ keyPolarity);
    wire [1:0] extHit  = extEnable & extActive;
    wire       anyKey  = |keyHit;
    wire       anyExt  = |extHit;
    wire       extHeld = |(wakeLines & extActive);
    wire       keyDone = keyCount == KEY_LAST[10:0];

    // =====================================================
    // mode sequencing; reset pin outranks every other wake
    always_comb begin
        next_state   = state;
        next_wakeSrc = wakeSrc;
        unique case (state)
            prmc_pkg::PRMC_RUN: begin
                if (sleepReq) begin
                    next_state = prmc_pkg::PRMC_PDOWN;
                end else if (haltReq) begin
                    next_state = prmc_pkg::PRMC_IDLE;
                end
            end
            prmc_pkg::PRMC_IDLE: begin
                if (rstPin) begin
                    next_state = prmc_pkg::PRMC_RUN;
                end else if (irqPending) begin
                    next_state   = prmc_pkg::PRMC_RUN;
                    next_wakeSrc = prmc_pkg::PRMC_WAKE_IRQ;
                end
            end
            prmc_pkg::PRMC_PDOWN: begin
                if (rstPin) begin
                    next_state = prmc_pkg::PRMC_RUN;
                end else if (anyExt) begin
                    next_state   = prmc_pkg::PRMC_HOLD_EXT;
                    next_wakeSrc = prmc_pkg::PRMC_WAKE_EXT;
                end else if (anyKey) begin
                    next_state   = prmc_pkg::PRMC_HOLD_KEY;
                    next_wakeSrc = prmc_pkg::PRMC_WAKE_KEY;
                end
            end
            prmc_pkg::PRMC_HOLD_EXT: begin
                if (rstPin || !extHeld) begin
                    next_state = prmc_pkg::PRMC_RUN;
                end
            end
            prmc_pkg::PRMC_HOLD_KEY: begin
                if (rstPin || keyDone) begin
                    next_state = prmc_pkg::PRMC_RUN;
                end
            end
            default: begin
                next_state = prmc_pkg::PRMC_RUN;
            end
        endcase
    end

    // =====================================================
    // clock gates follow the next mode so outputs match state
    // nothing else is touched while frozen, so cpu and ram state stay
    wire nextIdle  = next_state == prmc_pkg::PRMC_IDLE;
    wire nextPdown = next_state == prmc_pkg::PRMC_PDOWN;
    wire nextHold  = next_state == prmc_pkg::PRMC_HOLD_EXT || next_state == prmc_pkg::PRMC_HOLD_KEY;
    wire [2:0] next_clk = {~nextPdown, ~nextPdown, ~(nextPdown | nextIdle)};

    // =====================================================
    // request bits: software write masked by lock, hardware clear on wake
    // a write in the wake cycle wins, so a fresh request is never lost
    wire leaving   = (state != prmc_pkg::PRMC_RUN) && (next_state != state);
    wire wakeClear = (state == prmc_pkg::PRMC_IDLE || state == prmc_pkg::PRMC_PDOWN) && leaving;
    wire setHalt   = wb_dat_i[`PRMC_BIT_HALT] & ~lockBit;
    wire setSleep  = wb_dat_i[`PRMC_BIT_SLEEP] & ~lockBit;
    wire next_halt  = wrCtrl ? setHalt : (wakeClear ? 1'b0 : haltReq);
    wire next_sleep = wrCtrl ? setSleep : (wakeClear ? 1'b0 : sleepReq);

    // =====================================================
    // read data mux; unmapped offsets read zero and still ack
    wire [31:0] ctrlWord = {27'h0, spareB, spareA, lockBit, sleepReq, haltReq};
    wire [31:0] cfgWord  = {22'h0, extEnable, keyEnable, keyPolarity};
    wire [31:0] statWord = {22'h0, execHold, ramAccessBlock, 2'h0, wakeSrc, 1'b0, state};
    wire [31:0] readWord = hitCtrl ? ctrlWord : hitCfg ? cfgWord : hitStat ? statWord : 32'h0;

    // =====================================================
    // mode, gates and hold
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state    <= prmc_pkg::PRMC_RUN;
            wakeSrc  <= prmc_pkg::PRMC_WAKE_NONE;
            clkGate  <= 3'h7;
            execHold <= 1'b0;
        end else begin
            state    <= next_state;
            wakeSrc  <= next_wakeSrc;
            clkGate  <= next_clk;
            execHold <= nextHold;
        end
    end

    // =====================================================
    // ram block after a reset pin wake, until internal reset arrives
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ramAccessBlock <= 1'b0;
        end else if (rstPin && state != prmc_pkg::PRMC_RUN) begin
            ramAccessBlock <= 1'b1;
        end
    end

    // =====================================================
    // key wake counter and latched wake lines
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            keyCount  <= 11'h0;
            wakeLines <= 2'h0;
        end else begin
            keyCount  <= (state == prmc_pkg::PRMC_HOLD_KEY) ? keyCount + 11'h1 : 11'h0;
            wakeLines <= (state == prmc_pkg::PRMC_PDOWN) ? extHit : wakeLines;
        end
    end

    // =====================================================
    // control register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            haltReq  <= 1'b0;
            sleepReq <= 1'b0;
            lockBit  <= 1'b0;
            spareA   <= 1'b0;
            spareB   <= 1'b0;
        end else begin
            haltReq  <= next_halt;
            sleepReq <= next_sleep;
            if (wrCtrl) begin
                lockBit <= wb_dat_i[`PRMC_BIT_LOCK];
                spareA  <= wb_dat_i[`PRMC_BIT_SPARE_A];
                spareB  <= wb_dat_i[`PRMC_BIT_SPARE_B];
            end
        end
    end

    // =====================================================
    // wake configuration register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            keyPolarity <= `PRMC_RST_KEY_POL;
            keyEnable   <= `PRMC_RST_KEY_EN;
            extEnable   <= `PRMC_RST_EXT_EN;
        end else begin
            if (wrCfgLo) begin
                keyPolarity <= wb_dat_i[`PRMC_POS_KEY_POL +: 4];
                keyEnable   <= wb_dat_i[`PRMC_POS_KEY_EN +: 4];
            end
            if (wrCfgHi) begin
                extEnable <= wb_dat_i[`PRMC_POS_EXT_EN +: 2];
            end
        end
    end

    // =====================================================
    // bus answer: ack one cycle after the request, then drop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? readWord : wb_dat_o;
        end
    end

    // =====================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_lock_blocks_set: assert property ($rose(haltReq) || $rose(sleepReq) |-> $past(!lockBit))
        else $error("request set while lock held");
    a_idle_entry: assert property (state == prmc_pkg::PRMC_RUN && haltReq && !sleepReq
        |=> state == prmc_pkg::PRMC_IDLE)
        else $error("halt request did not enter idle");
    a_both_pdown: assert property (state == prmc_pkg::PRMC_RUN && haltReq && sleepReq
        |=> state == prmc_pkg::PRMC_PDOWN)
        else $error("halt with sleep did not enter power-down");
    a_idle_gates: assert property (state == prmc_pkg::PRMC_IDLE
        |-> !clkGate.cpu && clkGate.periph && clkGate.osc)
        else $error("idle clock gates wrong");
    a_pdown_gates: assert property (state == prmc_pkg::PRMC_PDOWN |-> clkGate == 3'h0)
        else $error("power-down clock gates wrong");
    a_idle_irq_exit: assert property (state == prmc_pkg::PRMC_IDLE && irqPending && !rstPin
        |=> state == prmc_pkg::PRMC_RUN && !haltReq && clkGate.cpu)
        else $error("interrupt did not end idle");
    a_reset_pin_wake: assert property ((state == prmc_pkg::PRMC_IDLE || state == prmc_pkg::PRMC_PDOWN) && rstPin
        |=> state == prmc_pkg::PRMC_RUN && ramAccessBlock && !sleepReq && clkGate == 3'h7)
        else $error("reset pin wake wrong");
    a_ext_hold_wait: assert property (state == prmc_pkg::PRMC_HOLD_EXT && extHeld && !rstPin
        |=> state == prmc_pkg::PRMC_HOLD_EXT && execHold)
        else $error("execution released while wake line held");
    a_pdown_no_idle: assert property (state == prmc_pkg::PRMC_PDOWN && anyExt && !rstPin
        |=> !haltReq && !sleepReq && clkGate.osc ##1 state != prmc_pkg::PRMC_IDLE)
        else $error("power-down wake fell into idle");
    a_key_count_end: assert property (state == prmc_pkg::PRMC_HOLD_KEY && keyDone && !rstPin
        |=> state == prmc_pkg::PRMC_RUN && !execHold)
        else $error("key wake did not end on count");
    a_key_count_wait: assert property (state == prmc_pkg::PRMC_HOLD_KEY && !keyDone && !rstPin
        |=> state == prmc_pkg::PRMC_HOLD_KEY && execHold)
        else $error("key wake ended early");

    c_idle_irq: cover property (state == prmc_pkg::PRMC_IDLE ##1 state == prmc_pkg::PRMC_RUN);
    c_ext_wake: cover property (state == prmc_pkg::PRMC_HOLD_EXT ##1 state == prmc_pkg::PRMC_RUN);
    c_key_wake: cover property (state == prmc_pkg::PRMC_HOLD_KEY && keyDone);
    c_rst_wake: cover property ($rose(ramAccessBlock));

endmodule : prmc_ctrl

`default_nettype wire

//--- dv/prmc_pin_model.sv
// far side model: external wake irq lines, key wake pins, reset pin
// assumes the bench commands levels; pins change only after sys_clk rises
`timescale 1ns/100ps
`default_nettype none

module prmc_pin_model (
    // clock
    input  wire logic       sys_clk,
    // commands from the bench
    input  wire logic [1:0] extCmd,
    input  wire logic [3:0] keyCmd,
    input  wire logic [3:0] keyPol,
    input  wire logic       rstCmd,
    // pins toward the controller
    output logic            extIrqA_n,
    output logic            extIrqB_n,
    output logic [3:0]      keyWakeInputs,
    output logic            resetPinLevel
);
    // =====================================================
    // pin levels
    // idle levels from time zero so no wake is seen before commands
    initial begin
        extIrqA_n     = 1'b1;
        extIrqB_n     = 1'b1;
        keyWakeInputs = ~keyPol;
        resetPinLevel = 1'b0;
    end

    // level irqs stay low as long as commanded, long enough to restart
    always @(posedge sys_clk) begin
        extIrqA_n     <= ~extCmd[0];
        extIrqB_n     <= ~extCmd[1];
        keyWakeInputs <= ~(keyCmd ^ keyPol);
        resetPinLevel <= rstCmd;
    end
endmodule : prmc_pin_model

`default_nettype wire

//--- dv/power_reduction_mode_control_bench.sv
// self-checking bench of the power reduction mode controller
// assumes prmc_ctrl with a short key wake count and a pin model beside it
`timescale 1ns/100ps
`default_nettype none
`include "prmc_regs.svh"

module power_reduction_mode_control_bench;
    localparam int KW = 8; // short key wake count keeps the run brief
    logic         sys_clk = 1'b0;
    logic         reset = 1'b1;
    logic         wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, rdBusy = 1'b0;
    logic [7:0]   wbAdr = 8'h00;
    logic [31:0]  wbDat = 32'h0, wbDatO, spr;
    logic         wbAck, irqPending = 1'b0, execHold, ramAccessBlock, rstCmd = 1'b0;
    logic         extA_n, extB_n, rstPin;
    logic [1:0]   extCmd = 2'h0;
    logic [3:0]   keyCmd = 4'h0, keyPol = 4'h0, keys;
    logic [63:0]  expQ[$];
    logic [63:0]  note;
    prmc_pkg::prmc_clk_type clkGate;
    int           seed, fail_count = 0, tests_run = 0, n;

    prmc_ctrl #(.KEY_WAKE_CLOCKS(KW)) prmc_ctrl_i (.sys_clk(sys_clk), .reset(reset),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irqPending(irqPending),
        .extIrqA_n(extA_n), .extIrqB_n(extB_n), .keyWakeInputs(keys), .resetPinLevel(rstPin),
        .clkGate(clkGate), .execHold(execHold), .ramAccessBlock(ramAccessBlock));
    prmc_pin_model prmc_pin_model_i (.sys_clk(sys_clk), .extCmd(extCmd), .keyCmd(keyCmd),
        .keyPol(keyPol), .rstCmd(rstCmd), .extIrqA_n(extA_n), .extIrqB_n(extB_n),
        .keyWakeInputs(keys), .resetPinLevel(rstPin));

    always #2 sys_clk = ~sys_clk;

    // =====================================================
    // reporting
    task automatic miss(input string s);
        $display("mismatch at %0t: %s", $time, s);
        fail_count++;
    endtask : miss

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // read data taken at the rising edge that samples ack high
    always @(posedge sys_clk) begin
        if (wbAck === 1'b1 && rdBusy) begin
            note = expQ.pop_front();
            tests_run++;
            if ((wbDatO & note[31:0]) !== note[63:32]) begin
                miss($sformatf("read %h, expected %h", wbDatO & note[31:0], note[63:32]));
            end
        end
    end

    // =====================================================
    // classic wishbone single cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d, input logic [31:0] m);
        if (!we) expQ.push_back({d & m, m});
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbDat  <= we ? d : 32'h0;
        rdBusy <= !we;
        // no cycle count assumed; only the watchdog ends a missing answer
        do begin
            @(posedge sys_clk);
        end while (wbAck !== 1'b1);
        wbCyc  <= 1'b0;
        wbStb  <= 1'b0;
        rdBusy <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // waits for gate and hold levels under a bounded count
    task automatic gates(input logic [2:0] g, input logic h);
        int k;
        k = 0;
        while ((clkGate !== g || execHold !== h) && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        tests_run++;
        if (k >= 40) miss($sformatf("gates %b hold %b, expected %b %b", clkGate, execHold, g, h));
    endtask : gates

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc

    // =====================================================
    // main sequence
    initial begin
        seed = 84136;
        keyPol = 4'($random(seed));
        spr = {27'h0, 2'($random(seed)), 3'h0};
        cyc(6);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(8'h00, 0, 32'h0, 32'hffffffff);
        bus(8'h04, 0, 32'h3f0, 32'h3ff);
        bus(8'h08, 1, 32'hffffffff, 0);
        bus(8'h08, 0, 32'h0, 32'h337);
        bus(8'h0c, 1, 32'hffffffff, 0);
        bus(8'h0c, 0, 32'h0, 32'hffffffff);
        bus(8'h04, 1, {22'h0, 10'h3f0} | keyPol, 0);
        bus(8'h00, 1, spr | 32'h4, 0);
        bus(8'h00, 1, spr | 32'h7, 0);
        bus(8'h00, 0, spr | 32'h4, 32'h1f);
        gates(3'b111, 0);
        bus(8'h00, 1, spr, 0);
        bus(8'h00, 1, spr | 32'h1, 0);
        gates(3'b110, 0);
        bus(8'h00, 0, spr | 32'h1, 32'h1f);
        irqPending <= 1'b1;
        cyc(2);
        irqPending <= 1'b0;
        gates(3'b111, 0);
        bus(8'h00, 0, spr, 32'h1f);
        bus(8'h08, 0, 32'h10, 32'h37);
        for (int i = 0; i < 2; i++) begin
            bus(8'h00, 1, spr | 32'h3, 0);
            gates(3'b000, 0);
            irqPending <= 1'b1;
            cyc(4);
            irqPending <= 1'b0;
            gates(3'b000, 0);
            extCmd[i] <= 1'b1;
            gates(3'b111, 1);
            bus(8'h00, 0, spr, 32'h1f);
            cyc(20);
            tests_run++;
            if (execHold !== 1'b1) miss("hold ended while line low");
            extCmd[i] <= 1'b0;
            gates(3'b111, 0);
            bus(8'h08, 0, 32'h20, 32'h37);
            bus(8'h04, 0, {22'h0, 10'h3f0} | keyPol, 32'h3ff);
        end
        for (int i = 0; i < 4; i++) begin
            bus(8'h00, 1, spr | 32'h2, 0);
            gates(3'b000, 0);
            keyCmd[i] <= 1'b1;
            gates(3'b111, 1);
            n = 0;
            while (execHold === 1'b1 && n < 2000) begin
                @(posedge sys_clk);
                n++;
            end
            tests_run++;
            if (n != KW) miss($sformatf("key hold %0d cycles", n));
            keyCmd[i] <= 1'b0;
            cyc(4);
            bus(8'h08, 0, 32'h30, 32'h37);
        end
        for (int i = 1; i < 3; i++) begin
            bus(8'h00, 1, spr | i, 0);
            gates(i == 1 ? 3'b110 : 3'b000, 0);
            rstCmd <= 1'b1;
            gates(3'b111, 0);
            bus(8'h00, 0, spr, 32'h1f);
            bus(8'h08, 0, 32'h100, 32'h107);
            tests_run++;
            if (ramAccessBlock !== 1'b1) miss("ram not blocked");
            rstCmd <= 1'b0;
            cyc(4);
        end
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(8'h08, 0, 32'h0, 32'h337);
        give_verdict();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        cyc(30000);
        miss("watchdog expired");
        give_verdict();
    end
endmodule : power_reduction_mode_control_bench

`default_nettype wire
